// [common/cmo_pkg.sv]
// shared constants for the comparator one control register bank
package cmo_pkg;
    // register byte offsets
    localparam logic [31:0] CMO_CTRL_OFFSET = 32'h0000_0000;
    localparam logic [31:0] CMO_VREF_OFFSET = 32'h0000_0004;
    // comparator_one_control field positions
    localparam int CMO_BIT_ENABLE = 7;
    localparam int CMO_BIT_RESULT = 6;
    localparam int CMO_BIT_PIN_DRIVE = 5;
    localparam int CMO_BIT_INVERT = 4;
    localparam int CMO_BIT_SPEED = 3;
    localparam int CMO_BIT_REF = 2;
    localparam int CMO_CHAN_LSB = 0;
    localparam int CMO_CHAN_W = 2;
    // voltage reference control field position
    localparam int CMO_BIT_VREF_ON = 0;
    // reset values
    localparam logic [7:0] CMO_CTRL_RESET = 8'h00;
    localparam logic CMO_VREF_RESET = 1'b0;
    // writable bits of the control register; the result bit is read-only
    localparam logic [7:0] CMO_CTRL_WMASK = 8'hBF;
    // AXI response codes
    localparam logic [1:0] CMO_RESP_OKAY = 2'h0;
    localparam logic [1:0] CMO_RESP_SLVERR = 2'h2;
endpackage

// [hdl/cmo_ctrl.sv]
// comparator one control register bank with an AXI4-Lite slave
`timescale 1ns/1ps
module cmo_ctrl
    import cmo_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic cmp_one_raw,
    output logic cmp_one_enable,
    output logic [1:0] cmp_one_channel,
    output logic cmp_one_ref_select,
    output logic cmp_one_speed_power,
    output logic vref_enable,
    output logic cmp_one_result,
    output logic cmp_one_pin_out,
    output logic cmp_one_pin_oe_n
);
    logic [7:0] ctrl_q;
    logic vref_q;
    logic raw_sync;
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr_q;
    logic w_held;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_fire;
    logic rd_fire;
    logic [1:0] wr_sel;
    logic [1:0] rd_sel;

    // bit 2 must exist to tell the two registers apart
    if (ADDR_W < 3 || ADDR_W > 32)
    begin : g_bad_addr_w
        $error("cmo_ctrl ADDR_W must lie in 3..32");
    end

    // bit 0 hits the control register, bit 1 the reference control
    function automatic logic [1:0] reg_hit(input logic [ADDR_W-1:0] a);
        logic [1:0] hit;
        hit = 2'h0;
        hit[0] = (a[ADDR_W-1:2] == CMO_CTRL_OFFSET[ADDR_W-1:2]);
        hit[1] = (a[ADDR_W-1:2] == CMO_VREF_OFFSET[ADDR_W-1:2]);
        return hit;
    endfunction

    // the analog result arrives asynchronously to aclk
    cmo_sync #(
        .STAGES(2)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(cmp_one_raw),
        .sync_out(raw_sync)
    );

    // write address and data are taken independently, in either order
    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign wr_sel = reg_hit(aw_addr_q);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            aw_addr_q <= '0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end
        else if (wr_fire)
            aw_held <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end
        else if (wr_fire)
            w_held <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= CMO_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_sel != 2'h0) ? CMO_RESP_OKAY : CMO_RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // only byte lane 0 carries register bits; other lanes are ignored
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ctrl_q <= CMO_CTRL_RESET;
        else if (wr_fire && wr_sel[0] && w_strb_q[0])
            ctrl_q <= w_data_q[7:0] & CMO_CTRL_WMASK;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            vref_q <= CMO_VREF_RESET;
        else if (wr_fire && wr_sel[1] && w_strb_q[0])
            vref_q <= w_data_q[CMO_BIT_VREF_ON];
    end

    // the result is registered so status bit and pin agree in the same cycle;
    // while off the invert bit alone sets the level, which lets software preset it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cmp_one_result <= 1'b0;
            cmp_one_pin_out <= 1'b0;
            cmp_one_pin_oe_n <= 1'b1;
        end
        else
        begin
            cmp_one_result <= (ctrl_q[CMO_BIT_ENABLE] & raw_sync) ^ ctrl_q[CMO_BIT_INVERT];
            cmp_one_pin_out <= (ctrl_q[CMO_BIT_ENABLE] & raw_sync) ^ ctrl_q[CMO_BIT_INVERT];
            cmp_one_pin_oe_n <= !(ctrl_q[CMO_BIT_PIN_DRIVE] && ctrl_q[CMO_BIT_ENABLE]);
        end
    end

    assign cmp_one_enable = ctrl_q[CMO_BIT_ENABLE];
    assign cmp_one_channel = ctrl_q[CMO_CHAN_LSB +: CMO_CHAN_W];
    assign cmp_one_ref_select = ctrl_q[CMO_BIT_REF];
    assign cmp_one_speed_power = ctrl_q[CMO_BIT_SPEED];
    assign vref_enable = vref_q;

    // one read at a time; data sampled at the address handshake
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign rd_sel = reg_hit(s_axi_araddr);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= CMO_RESP_OKAY;
        end
        else if (rd_fire)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= CMO_RESP_OKAY;
            if (rd_sel[0])
            begin
                s_axi_rdata <= {24'h00_0000, ctrl_q};
                s_axi_rdata[CMO_BIT_RESULT] <= cmp_one_result;
            end
            else if (rd_sel[1])
                s_axi_rdata <= {31'h0000_0000, vref_q};
            else
            begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= CMO_RESP_SLVERR;
            end
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    property p_reset_clear;
        @(posedge aclk) $fell(aresetn) |=> (ctrl_q == CMO_CTRL_RESET) && !vref_q;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("registers not cleared by reset");

    property p_off_after_reset;
        @(posedge aclk) disable iff (!aresetn)
        $rose(aresetn) |-> !cmp_one_enable && !vref_enable && cmp_one_pin_oe_n;
    endproperty
    a_off_after_reset: assert property (p_off_after_reset) else $error("not off after reset");

    property p_inverted;
        @(posedge aclk) disable iff (!aresetn)
        (ctrl_q[CMO_BIT_ENABLE] && ctrl_q[CMO_BIT_INVERT]) |=> (cmp_one_result == !$past(raw_sync));
    endproperty
    a_inverted: assert property (p_inverted) else $error("inverted result wrong");

    property p_plain;
        @(posedge aclk) disable iff (!aresetn)
        (ctrl_q[CMO_BIT_ENABLE] && !ctrl_q[CMO_BIT_INVERT]) |=> (cmp_one_result == $past(raw_sync));
    endproperty
    a_plain: assert property (p_plain) else $error("non-inverted result wrong");

    property p_pin_drive;
        @(posedge aclk) disable iff (!aresetn)
        (wr_fire && wr_sel[0] && w_strb_q[0]) |=> ##1
        (cmp_one_pin_oe_n == !($past(w_data_q[CMO_BIT_PIN_DRIVE], 2) && $past(w_data_q[7], 2)));
    endproperty
    a_pin_drive: assert property (p_pin_drive) else $error("pin drive not following write");

    property p_pin_matches;
        @(posedge aclk) disable iff (!aresetn)
        cmp_one_pin_out == cmp_one_result;
    endproperty
    a_pin_matches: assert property (p_pin_matches) else $error("pin and status disagree");

    property p_enable_write;
        @(posedge aclk) disable iff (!aresetn)
        (wr_fire && wr_sel[0] && w_strb_q[0]) |=> (cmp_one_enable == $past(w_data_q[CMO_BIT_ENABLE]));
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable not written");

    property p_channel_write;
        @(posedge aclk) disable iff (!aresetn)
        (wr_fire && wr_sel[0] && w_strb_q[0]) |=> (cmp_one_channel == $past(w_data_q[1:0]));
    endproperty
    a_channel_write: assert property (p_channel_write) else $error("channel not written");

    property p_ref_speed_write;
        @(posedge aclk) disable iff (!aresetn)
        (wr_fire && wr_sel[0] && w_strb_q[0]) |=>
        (cmp_one_ref_select == $past(w_data_q[CMO_BIT_REF]))
        && (cmp_one_speed_power == $past(w_data_q[CMO_BIT_SPEED]));
    endproperty
    a_ref_speed_write: assert property (p_ref_speed_write) else $error("ref or speed wrong");

    property p_off_level;
        @(posedge aclk) disable iff (!aresetn)
        !ctrl_q[CMO_BIT_ENABLE] |=> (cmp_one_result == $past(ctrl_q[CMO_BIT_INVERT]));
    endproperty
    a_off_level: assert property (p_off_level) else $error("off level not set by invert");

    c_write_ctrl: cover property (@(posedge aclk) disable iff (!aresetn) wr_fire && wr_sel[0]);
    c_read_ctrl: cover property (@(posedge aclk) disable iff (!aresetn) rd_fire && rd_sel[0]);
    c_pin_driven: cover property (@(posedge aclk) disable iff (!aresetn) !cmp_one_pin_oe_n && cmp_one_pin_out);
    c_bad_addr: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_rvalid && s_axi_rresp == CMO_RESP_SLVERR);
endmodule // cmo_ctrl

// [hdl/cmo_sync.sv]
// multi-stage synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
module cmo_sync #(
    parameter int STAGES = 2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic async_in,
    output logic sync_out
);
    logic [STAGES-1:0] chain;

    // refused at elaboration: fewer than two stages would let metastability through
    if (STAGES < 2)
    begin : g_bad_stages
        $error("cmo_sync needs at least two stages");
    end

    // the first stage is read only by the next stage
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            chain <= '0;
        else
            chain <= {chain[STAGES-2:0], async_in};
    end

    assign sync_out = chain[STAGES-1];
endmodule // cmo_sync

// [test/cmo_ctrl_tb.sv]
// self-checking bench for the comparator one control register bank
`timescale 1ns/1ps
module testbench;
    import cmo_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic [11:0] araddr = 12'h000;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic raw = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, ch;
    logic [31:0] rdata;
    logic en, refs, spd, vref_en, res, pin_out, oe_n;
    logic [7:0] ctrl_m;
    logic vref_m;
    logic [1:0] r;
    logic [31:0] d;
    logic [31:0] rnd;
    integer seed = 32'h7392E7E7;
    integer n_fail = 0;
    integer n_compared = 0;
    integer i;

    cmo_ctrl #(.ADDR_W(12)) dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cmp_one_raw(raw),
        .cmp_one_enable(en), .cmp_one_channel(ch), .cmp_one_ref_select(refs),
        .cmp_one_speed_power(spd), .vref_enable(vref_en), .cmp_one_result(res),
        .cmp_one_pin_out(pin_out), .cmp_one_pin_oe_n(oe_n));

    always #20 aclk = ~aclk;

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp)
        begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task axi_wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= v;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done)
        begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready)
            begin
                r = bresp;
                done = 1'b1;
            end
        end
        bready <= 1'b0;
    endtask

    task axi_rd(input logic [11:0] a);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done)
        begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready)
            begin
                d = rdata;
                r = rresp;
                done = 1'b1;
            end
        end
        rready <= 1'b0;
    endtask

    task set_ctrl(input logic [7:0] v);
        axi_wr(CMO_CTRL_OFFSET[11:0], {24'h0, v}, 4'hF);
        ctrl_m = v & CMO_CTRL_WMASK;
        check({30'h0, r}, {30'h0, CMO_RESP_OKAY});
    endtask

    // waits out the two-stage synchroniser plus the pin enable lag
    task check_all;
        logic e;
        e = (ctrl_m[7] & raw) ^ ctrl_m[4];
        repeat (5) @(posedge aclk);
        check({31'h0, res}, {31'h0, e});
        check({31'h0, pin_out}, {31'h0, e});
        check({31'h0, oe_n}, {31'h0, ~(ctrl_m[5] & ctrl_m[7])});
        check({26'h0, en, spd, refs, ch, vref_en},
              {26'h0, ctrl_m[7], ctrl_m[3:0], vref_m});
        axi_rd(CMO_CTRL_OFFSET[11:0]);
        check(d, {24'h0, ctrl_m[7], e, ctrl_m[5:0]});
        check({30'h0, r}, {30'h0, CMO_RESP_OKAY});
        axi_rd(CMO_VREF_OFFSET[11:0]);
        check(d, {31'h0, vref_m});
        check({30'h0, r}, {30'h0, CMO_RESP_OKAY});
    endtask

    task report_and_stop;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (8000) @(posedge aclk);
        n_fail = n_fail + 1;
        report_and_stop;
    end

    initial
    begin
        ctrl_m = 8'h00;
        vref_m = 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        check_all;
        $display("test reset values done");
        for (i = 0; i < 16; i = i + 1)
        begin
            set_ctrl({4'h0, i[3:0]});
            check_all;
        end
        $display("test channel reference speed done");
        // bit 6 is written as 1 every time to show it cannot be set
        for (i = 0; i < 16; i = i + 1)
        begin
            @(posedge aclk);
            raw <= i[0];
            set_ctrl({i[3], 1'b1, i[2], i[1], 4'h5});
            check_all;
        end
        $display("test polarity enable pin done");
        for (i = 0; i < 12; i = i + 1)
        begin
            @(posedge aclk);
            rnd = $random(seed);
            raw <= rnd[8];
            set_ctrl(rnd[7:0]);
            check_all;
        end
        $display("test random done");
        axi_wr(CMO_VREF_OFFSET[11:0], 32'h1, 4'hF);
        vref_m = 1'b1;
        set_ctrl(8'hFF);
        check_all;
        axi_wr(12'h010, 32'hFF, 4'hF);
        check({30'h0, r}, {30'h0, CMO_RESP_SLVERR});
        axi_wr(CMO_CTRL_OFFSET[11:0], 32'h0, 4'h0);
        check({30'h0, r}, {30'h0, CMO_RESP_OKAY});
        axi_rd(12'h010);
        check({d[31:2], r}, {30'h0, CMO_RESP_SLVERR});
        check_all;
        $display("test unmapped and strobe done");
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        ctrl_m = 8'h00;
        vref_m = 1'b0;
        check_all;
        $display("test mid-run reset done");
        report_and_stop;
    end
endmodule // testbench
